// ===== ata_cmd_defs.svh
// constants of the task-file and command acceptance block
`ifndef ATA_CMD_DEFS_SVH
`define ATA_CMD_DEFS_SVH
`define OFS_DATA 4'h0
`define OFS_ERROR 4'h1
`define OFS_COUNT 4'h2
`define OFS_SECTOR 4'h3
`define OFS_CYL_LO 4'h4
`define OFS_CYL_HI 4'h5
`define OFS_DRV_HEAD 4'h6
`define OFS_STATUS 4'h7
`define OFS_ALT_CTRL 4'he
`define OFS_DRV_ADDR 4'hf
`define DH_LBA_BIT 6
`define DH_DRV_BIT 4
`define CTRL_SRST_BIT 2
`define CTRL_NIEN_BIT 1
`define ERR_ABORT 8'h04
`define DIAG_NO_ERROR 8'h01
`define PWR_SLEEP_COUNT 8'h00
`define PWR_IDLE_COUNT 8'hff
`define FILL_BYTE 8'hff
`define SECTOR_BYTES 512
`define CLK_NS 20
`define BUSY_NS 400
`define DRQ2_US 700
`define DRQ3_MS 20
`define BUSY_CYC (`BUSY_NS / `CLK_NS)
`define DRQ2_CYC ((`DRQ2_US * 1000) / `CLK_NS)
`define DRQ3_CYC ((`DRQ3_MS * 1000000) / `CLK_NS)
`endif

// ===== ata_cmd_pkg.sv
// types shared by the command acceptance block
package ata_cmd_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_POWER, S_SETUP, S_XFER, S_WAIT
  } state_type;
  typedef struct packed {
    logic known;
    logic [1:0] cls;
    logic drive_only;
    logic legacy;
  } cmd_info_type;
  typedef struct packed {
    logic ce_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] addr;
    logic [7:0] wdata;
  } host_bus_type;
endpackage : ata_cmd_pkg

// ===== ata_command_acceptance.sv
// task-file registers and command acceptance of the card
`timescale 1ns/1ps
`include "ata_cmd_defs.svh"
module ata_command_acceptance #(
  parameter int unsigned DRQ2_CYC = `DRQ2_CYC,
  parameter int unsigned DRQ3_CYC = `DRQ3_CYC,
  parameter int unsigned SECTOR_BYTES = `SECTOR_BYTES
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // host task-file pins
  input wire ata_cmd_pkg::host_bus_type host_pins,
  output logic [7:0] rdata,
  output logic [7:0] rdata_oe_n,
  output logic intrq,
  // straps
  input wire logic card_is_drive1,
  input wire logic drive_addr_off,
  // media engine side
  input wire logic write_active,
  input wire logic power_sleep,
  input wire logic buf_ready,
  input wire logic cmd_done,
  input wire logic cmd_fail,
  input wire logic [7:0] diag_result,
  output logic cmd_start,
  output logic [7:0] cmd_code,
  output logic [27:0] cmd_addr,
  output logic cmd_drive,
  output logic [8:0] cmd_count,
  output logic cmd_erase,
  output logic [7:0] fill_byte,
  output logic data_wr,
  output logic [7:0] data_byte
);
  localparam int BUSY_CYC = `BUSY_CYC;
  localparam int unsigned TW = $clog2(DRQ3_CYC + 1);
  localparam int unsigned BW = $clog2(SECTOR_BYTES);

  // pin synchronisation
  ata_cmd_pkg::host_bus_type bus_q;
  logic [3:0] misc_q;
  sync3 #(.WIDTH(19), .INIT(19'h7_0000)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d({host_pins, card_is_drive1, drive_addr_off, write_active,
        power_sleep}),
    .q({bus_q, misc_q})
  );
  wire drv1_q = misc_q[3];
  wire addr_off_q = misc_q[2];
  wire wact_q = misc_q[1];
  wire sleep_q = misc_q[0];

  // task-file state
  ata_cmd_pkg::state_type st_r;
  ata_cmd_pkg::cmd_info_type info_r;
  logic rd_prev_r;
  logic wr_prev_r;
  logic [7:0] count_r;
  logic [7:0] sector_r;
  logic [7:0] cyl_lo_r;
  logic [7:0] cyl_hi_r;
  logic [7:0] dh_r;
  logic [7:0] error_r;
  logic busy_r;
  logic drq_r;
  logic err_r;
  logic srst_r;
  logic nien_r;
  logic irq_r;
  logic fmt_r;
  logic diag_r;
  logic [TW-1:0] timer_r;
  logic [BW-1:0] bytes_r;

  // strobe edges and address decode
  wire sel = !bus_q.ce_n;
  wire rd_go = sel && rd_prev_r && !bus_q.rd_n;
  wire wr_go = sel && wr_prev_r && !bus_q.wr_n;
  wire [3:0] a = bus_q.addr;
  wire [7:0] wd = bus_q.wdata;
  wire at_stat = a == `OFS_STATUS;
  wire at_alt = a == `OFS_ALT_CTRL;
  wire at_dadr = a == `OFS_DRV_ADDR;
  wire rd_stat = rd_go && at_stat;
  wire rd_dadr = rd_go && at_dadr;
  wire wr_param = wr_go && !busy_r && !drq_r && a >= `OFS_COUNT
                  && a <= `OFS_DRV_HEAD;
  wire wr_cmd = wr_go && at_stat && !busy_r;
  wire wr_data = wr_go && a == `OFS_DATA && drq_r;
  wire last_byte = bytes_r == BW'(SECTOR_BYTES - 1);

  // command code classification
  function automatic ata_cmd_pkg::cmd_info_type classify(
      input logic [7:0] c);
    ata_cmd_pkg::cmd_info_type r;
    r = '{known: 1'b1, cls: 2'd1, drive_only: 1'b0, legacy: 1'b0};
    unique casez (c)
      8'he5, 8'h98, 8'hec, 8'he3, 8'h97, 8'he1, 8'h95, 8'he4, 8'h1?,
      8'h03, 8'hef, 8'hc6, 8'he6, 8'h99, 8'he2, 8'h96, 8'he0,
      8'h94: r.drive_only = 1'b1;
      8'h90, 8'hc0, 8'h91, 8'hc8, 8'hc9, 8'hc4, 8'h22, 8'h23, 8'h20,
      8'h21, 8'h40, 8'h41, 8'h7?, 8'h87, 8'hf5: r.cls = 2'd1;
      8'he8: begin
        r.cls = 2'd2;
        r.drive_only = 1'b1;
      end
      8'h50, 8'hca, 8'hcb, 8'h32, 8'h33, 8'h30, 8'h31,
      8'h3c: r.cls = 2'd2;
      8'h38: begin
        r.cls = 2'd2;
        r.legacy = 1'b1;
      end
      8'hcd: begin
        r.cls = 2'd3;
        r.legacy = 1'b1;
      end
      8'hc5: r.cls = 2'd3;
      default: r.known = 1'b0;
    endcase
    return r;
  endfunction : classify

  wire ata_cmd_pkg::cmd_info_type info_new = classify(wd);
  wire [7:0] dmask = info_new.drive_only ? 8'hf0 : 8'hff;
  wire drv_sel = dh_r[`DH_DRV_BIT];
  wire is_fmt = wd == 8'h50;
  wire [8:0] sc_full = (count_r == 8'h00) ? 9'h100 : {1'b0, count_r};

  // read value multiplexer
  wire [7:0] status_v = {busy_r | srst_r, !srst_r, 1'b0, !srst_r,
                         drq_r, 1'b0, 1'b0, err_r};
  wire [7:0] dadr_v = {1'b0, !wact_q, ~dh_r[3:0],
                       !(drv1_q && drv_sel),
                       !(!drv1_q && !drv_sel)};
  wire [7:0] read_v =
    (a == `OFS_ERROR) ? error_r :
    (a == `OFS_COUNT) ? count_r :
    (a == `OFS_SECTOR) ? sector_r :
    (a == `OFS_CYL_LO) ? cyl_lo_r :
    (a == `OFS_CYL_HI) ? cyl_hi_r :
    (a == `OFS_DRV_HEAD) ? dh_r :
    (at_stat || at_alt) ? status_v :
    at_dadr ? dadr_v : 8'h00;
  wire [7:0] oe_v = !(sel && !bus_q.rd_n) ? 8'hff :
                    !at_dadr ? 8'h00 :
                    addr_off_q ? 8'hff :
                    8'h80;

  // read data and enables, registered every cycle; only a status read has a side effect, clearing irq_r
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
      rdata_oe_n <= 8'hff;
      rd_prev_r <= 1'b1;
      wr_prev_r <= 1'b1;
    end else begin
      rdata <= read_v & ~oe_v;
      rdata_oe_n <= (sel && !bus_q.rd_n) ? oe_v : 8'hff;
      rd_prev_r <= bus_q.rd_n || bus_q.ce_n;
      wr_prev_r <= bus_q.wr_n || bus_q.ce_n;
    end
  end

  // device control register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      srst_r <= 1'b0;
      nien_r <= 1'b0;
    end else if (wr_go && at_alt) begin
      srst_r <= wd[`CTRL_SRST_BIT];
      nien_r <= wd[`CTRL_NIEN_BIT];
    end
  end

  // interrupt: set wins over the status-read clear
  wire irq_set = (st_r == ata_cmd_pkg::S_POWER)
              || (st_r == ata_cmd_pkg::S_WAIT && cmd_done)
              || (wr_cmd && !info_new.known);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
      intrq <= 1'b0;
    end else begin
      irq_r <= srst_r ? 1'b0 : irq_set ? 1'b1
             : rd_stat ? 1'b0 : irq_r;
      intrq <= irq_r && !nien_r;
    end
  end

  // parameter registers, locked out while busy
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sector_r <= 8'h01;
      cyl_lo_r <= 8'h00;
      cyl_hi_r <= 8'h00;
      dh_r <= 8'ha0;
    end else if (wr_param) begin
      if (a == `OFS_SECTOR) sector_r <= wd;
      if (a == `OFS_CYL_LO) cyl_lo_r <= wd;
      if (a == `OFS_CYL_HI) cyl_hi_r <= wd;
      if (a == `OFS_DRV_HEAD) dh_r <= wd | 8'ha0;
    end
  end

  // acceptance state machine
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= ata_cmd_pkg::S_IDLE;
      info_r <= '0;
      busy_r <= 1'b0;
      drq_r <= 1'b0;
      err_r <= 1'b0;
      error_r <= `DIAG_NO_ERROR;
      count_r <= 8'h01;
      fmt_r <= 1'b0;
      diag_r <= 1'b0;
      timer_r <= '0;
      bytes_r <= '0;
    end else if (srst_r) begin
      st_r <= ata_cmd_pkg::S_IDLE;
      busy_r <= 1'b0;
      drq_r <= 1'b0;
      err_r <= 1'b0;
      error_r <= `DIAG_NO_ERROR;
    end else begin
      if (wr_param && a == `OFS_COUNT) count_r <= wd;
      unique case (st_r)
        ata_cmd_pkg::S_IDLE: if (wr_cmd) begin
          info_r <= info_new;
          fmt_r <= is_fmt;
          diag_r <= wd == 8'h90;
          bytes_r <= '0;
          timer_r <= TW'(info_new.cls == 2'd3 ? DRQ3_CYC : DRQ2_CYC);
          err_r <= !info_new.known;
          error_r <= info_new.known ? 8'h00 : `ERR_ABORT;
          busy_r <= info_new.known;
          if (!info_new.known) st_r <= ata_cmd_pkg::S_IDLE;
          else if (wd == 8'he5 || wd == 8'h98) st_r <= ata_cmd_pkg::S_POWER;
          else if (info_new.cls == 2'd1) st_r <= ata_cmd_pkg::S_WAIT;
          else st_r <= ata_cmd_pkg::S_SETUP;
        end
        ata_cmd_pkg::S_POWER: begin
          count_r <= sleep_q ? `PWR_SLEEP_COUNT
                             : `PWR_IDLE_COUNT;
          busy_r <= 1'b0;
          st_r <= ata_cmd_pkg::S_IDLE;
        end
        ata_cmd_pkg::S_SETUP: begin
          timer_r <= timer_r - TW'(1);
          if (buf_ready || timer_r <= TW'(1)) begin
            drq_r <= 1'b1;
            busy_r <= 1'b0;
            st_r <= ata_cmd_pkg::S_XFER;
          end
        end
        ata_cmd_pkg::S_XFER: if (wr_data) begin
          bytes_r <= bytes_r + BW'(1);
          if (last_byte) begin
            drq_r <= 1'b0;
            busy_r <= 1'b1;
            st_r <= ata_cmd_pkg::S_WAIT;
          end
        end
        ata_cmd_pkg::S_WAIT: if (cmd_done) begin
          busy_r <= 1'b0;
          err_r <= cmd_fail && !diag_r;
          error_r <= diag_r ? diag_result
                   : cmd_fail ? `ERR_ABORT : 8'h00;
          st_r <= ata_cmd_pkg::S_IDLE;
        end
      endcase
    end
  end

  // command hand-off towards the media engine
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_start <= 1'b0;
      cmd_code <= 8'h00;
      cmd_addr <= '0;
      cmd_drive <= 1'b0;
      cmd_count <= 9'h000;
      cmd_erase <= 1'b0;
      fill_byte <= 8'h00;
      data_wr <= 1'b0;
      data_byte <= 8'h00;
    end else begin
      cmd_start <= wr_cmd && info_new.known && !srst_r;
      data_wr <= wr_data && !fmt_r && !srst_r;
      data_byte <= wd;
      if (wr_cmd && info_new.known) begin
        cmd_code <= wd;
        cmd_drive <= drv_sel;
        cmd_addr <= {dh_r[3:0] & dmask[3:0], cyl_hi_r, cyl_lo_r,
                     sector_r};
        cmd_count <= (is_fmt && !dh_r[`DH_LBA_BIT]) ? 9'h000
                   : sc_full;
        cmd_erase <= info_new.legacy || wd == 8'hc0;
        fill_byte <= is_fmt ? `FILL_BYTE : 8'h00;
      end
    end
  end

  // helper: cycles spent waiting for drq
  logic [TW-1:0] wait_cnt_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) wait_cnt_r <= '0;
    else if (st_r == ata_cmd_pkg::S_SETUP) wait_cnt_r <= wait_cnt_r + TW'(1);
    else wait_cnt_r <= '0;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  busy_after_cmd_a: assert property (wr_cmd && info_new.known && !srst_r
    |-> ##[1:BUSY_CYC] busy_r) else $error("busy late");
  drq2_deadline_a: assert property (st_r == ata_cmd_pkg::S_SETUP
    && info_r.cls == 2'd2 |-> wait_cnt_r < TW'(DRQ2_CYC))
    else $error("class 2 drq late");
  drq3_deadline_a: assert property (st_r == ata_cmd_pkg::S_SETUP
    |-> wait_cnt_r < TW'(DRQ3_CYC)) else $error("class 3 drq late");
  busy_drop_drq_a: assert property ($rose(drq_r)
    |-> ##[0:BUSY_CYC] !busy_r) else $error("busy held after drq");
  mirror_bits_a: assert property (rd_dadr && !addr_off_q
    |=> rdata_oe_n[7] && rdata[5:2] == ~$past(dh_r[3:0])
    && rdata_oe_n[6:0] == 7'h00) else $error("drive address wrong");
  drive_sel_a: assert property (rd_dadr && !addr_off_q |=> rdata[1:0]
    == ($past(drv1_q) ? {!$past(drv_sel), 1'b1} : {1'b1, $past(drv_sel)}))
    else $error("drive select bits wrong");
  addr_off_a: assert property (rd_dadr && addr_off_q |=> rdata_oe_n == 8'hff)
    else $error("drive address answered");
  power_count_a: assert property (st_r == ata_cmd_pkg::S_POWER
    |=> count_r == ($past(sleep_q) ? 8'h00 : 8'hff) && !busy_r ##1 irq_r)
    else $error("power check result wrong");
  class_decode_a: assert property (wr_cmd && !srst_r && wd == 8'hcd
    |=> st_r == ata_cmd_pkg::S_SETUP && info_r.cls == 2'd3)
    else $error("cdh not class 3");
  status_clear_a: assert property (rd_stat && !irq_set |=> !irq_r)
    else $error("status read kept irq");
  alt_keep_a: assert property (rd_go && at_alt && irq_r && !srst_r
    |=> irq_r) else $error("alternate read cleared irq");
  fmt_discard_a: assert property (fmt_r && st_r == ata_cmd_pkg::S_XFER
    |=> !data_wr) else $error("format data forwarded");

  class1_done_c: cover property (st_r == ata_cmd_pkg::S_WAIT ##1 irq_r);
  class2_drq_c: cover property (st_r == ata_cmd_pkg::S_SETUP ##1 drq_r);
  abort_c: cover property (wr_cmd && !info_new.known);
endmodule : ata_command_acceptance

// ===== media_model.sv
// media engine model answering the command starts of the block
`timescale 1ns/1ps
module media_model #(
  parameter int unsigned DELAY = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // command side
  input wire logic cmd_start,
  input wire logic [7:0] cmd_code,
  input wire logic slow,
  input wire logic done_req,
  input wire logic [7:0] diag_in,
  // answers
  output logic buf_ready,
  output logic cmd_done,
  output logic cmd_fail,
  output logic [7:0] diag_result
);
  logic [7:0] cnt_r;
  logic run_r;
  logic wr_r;
  logic req_r;
  // write codes wait for host data, power check needs no completion
  wire is_wr = cmd_code[7:4] == 4'h3 || cmd_code == 8'hcd ||
    cmd_code == 8'hc5 || cmd_code == 8'h50 || cmd_code == 8'he8;
  wire is_pwr = cmd_code == 8'he5 || cmd_code == 8'h98;
  assign cmd_fail = 1'b0;
  assign diag_result = diag_in;
  // slow mode never readies the buffer, so the block must time out
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      {cnt_r, run_r, wr_r, req_r, buf_ready, cmd_done} <= '0;
    end else begin
      req_r <= done_req;
      cmd_done <= 1'b0;
      if (cmd_start) begin
        run_r <= !is_pwr;
        wr_r <= is_wr;
        cnt_r <= 8'h00;
      end else if (run_r) begin
        cnt_r <= cnt_r + 8'h01;
        if (wr_r && !slow && cnt_r == 8'(DELAY)) buf_ready <= 1'b1;
        if (wr_r ? (done_req && !req_r) : cnt_r == 8'(DELAY)) begin
          cmd_done <= 1'b1;
          run_r <= 1'b0;
          buf_ready <= 1'b0;
        end
      end
    end
  end
endmodule : media_model

// ===== sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sync3 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // raw and filtered levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  wire [WIDTH-1:0] agree = ~(s2_r ^ s3_r);

  // a bit only moves once stages two and three agree
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q <= INIT;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q <= (q & ~agree) | (s2_r & agree);
    end
  end
endmodule : sync3

// ===== testbench.sv
// self-checking bench for the command acceptance block
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  ata_cmd_pkg::host_bus_type hb = '{1'b1, 1'b1, 1'b1, 4'h0, 8'h00};
  logic [7:0] rdata, rdata_oe_n, cmd_code, fill_byte, diag_result;
  logic [7:0] diag_in = 8'h01;
  logic intrq, cmd_start, cmd_erase, data_wr, buf_ready, cmd_done;
  logic cmd_fail, st_erase;
  logic [27:0] cmd_addr;
  logic [8:0] cmd_count, st_count;
  logic [7:0] st_fill, st_byte, data_byte;
  logic cmd_drive, st_drive;
  logic [3:0] st_head;
  logic drive1 = 1'b0, addr_off = 1'b0, sleep = 1'b0;
  logic slow = 1'b0, done_req = 1'b0;
  int starts = 0, wrs = 0, mismatches = 0, tests_run = 0;

  always #10 clock = ~clock;

  ata_command_acceptance #(.DRQ2_CYC(20), .DRQ3_CYC(40),
    .SECTOR_BYTES(4)) ata_command_acceptance_inst (
    .clock(clock), .nrst(nrst), .host_pins(hb), .rdata(rdata),
    .rdata_oe_n(rdata_oe_n), .intrq(intrq), .card_is_drive1(drive1),
    .drive_addr_off(addr_off), .write_active(1'b0),
    .power_sleep(sleep), .buf_ready(buf_ready), .cmd_done(cmd_done),
    .cmd_fail(cmd_fail), .diag_result(diag_result),
    .cmd_start(cmd_start), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
    .cmd_drive(cmd_drive), .cmd_count(cmd_count), .cmd_erase(cmd_erase),
    .fill_byte(fill_byte), .data_wr(data_wr), .data_byte(data_byte));

  media_model media_model_inst (
    .clock(clock), .nrst(nrst), .cmd_start(cmd_start),
    .cmd_code(cmd_code), .slow(slow), .done_req(done_req),
    .diag_in(diag_in), .buf_ready(buf_ready), .cmd_done(cmd_done),
    .cmd_fail(cmd_fail), .diag_result(diag_result));

  // capture of what each accepted command hands to the media side,
  // mid-cycle so that it never races the edge that launches it
  always @(negedge clock) begin
    if (cmd_start === 1'b1) begin
      starts++;
      st_count = cmd_count;
      st_erase = cmd_erase;
      st_fill = fill_byte;
      st_head = cmd_addr[27:24];
      st_drive = cmd_drive;
    end
    if (data_wr === 1'b1) begin
      wrs++;
      st_byte = data_byte;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  // address settles before the strobe, strobes held past the filter
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    hb = '{1'b1, 1'b1, 1'b1, a, d};
    cyc(2);
    hb = '{1'b0, 1'b1, 1'b0, a, d};
    cyc(6);
    hb = '{1'b1, 1'b1, 1'b1, a, d};
    cyc(6);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d, oe);
    hb = '{1'b1, 1'b1, 1'b1, a, 8'h00};
    cyc(2);
    hb = '{1'b0, 1'b0, 1'b1, a, 8'h00};
    cyc(6);
    d = rdata;
    oe = rdata_oe_n;
    hb = '{1'b1, 1'b1, 1'b1, a, 8'h00};
    cyc(6);
  endtask : rd

  task automatic chk(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // status polls until the data request shows, bounded
  task automatic poll(input int max, output logic [7:0] first, s);
    int i;
    logic [7:0] oe;
    for (i = 0; i < 8; i++) begin
      rd(4'h7, s, oe);
      if (i == 0) first = s;
      if (s[3]) break;
    end
    chk("drq wait", 16'h1, 16'(i <= max));
    if (i == 8) report_and_stop();
  endtask : poll

  task automatic t_mirror;
    logic [7:0] d, oe;
    logic [7:0] dh [3] = '{8'ha5, 8'hb0, 8'hb5};
    logic [7:0] ex [3] = '{8'h6a, 8'h7f, 8'h69};
    rd(4'h6, d, oe);
    chk("drive head reset", 8'ha0, d);
    for (int k = 0; k < 3; k++) begin
      drive1 = k == 2;
      wr(4'h6, dh[k]);
      rd(4'hf, d, oe);
      chk("mirror", ex[k], d);
      chk("mirror enables", 8'h80, oe);
    end
    rd(4'h7, d, oe);
    chk("status after mirror", 8'h50, d);
    addr_off = 1'b1;
    cyc(6);
    rd(4'hf, d, oe);
    chk("mirror off", 8'hff, oe);
    addr_off = 1'b0;
    $display("test mirror done");
  endtask : t_mirror

  task automatic t_power;
    logic [7:0] d, oe;
    logic [7:0] code [2] = '{8'he5, 8'h98};
    logic [7:0] ex [2] = '{8'h00, 8'hff};
    wr(4'h6, 8'hb5);
    for (int k = 0; k < 2; k++) begin
      sleep = k == 0;
      wr(4'h2, 8'h55);
      wr(4'h7, code[k]);
      cyc(6);
      chk("irq raised", 16'h1, intrq);
      rd(4'he, d, oe);
      chk("irq after alt", 16'h1, intrq);
      rd(4'h2, d, oe);
      chk("power count", ex[k], d);
      chk("head ignored", 4'h0, st_head);
      chk("drive used", 16'h1, st_drive);
      rd(4'h7, d, oe);
      chk("power status", 8'h50, d);
      cyc(2);
      chk("irq cleared", 16'h0, intrq);
    end
    $display("test power done");
  endtask : t_power

  task automatic t_class1;
    logic [7:0] d, oe;
    logic [7:0] dg [4] = '{8'h01, 8'h02, 8'h05, 8'h81};
    logic [7:0] cc [4] = '{8'h87, 8'hf5, 8'h03, 8'hc0};
    int n;
    for (int k = 0; k < 4; k++) begin
      diag_in = dg[k];
      wr(4'h7, 8'h90);
      cyc(6);
      rd(4'h1, d, oe);
      chk("diag code", dg[k], d);
      rd(4'h7, d, oe);
      n = starts;
      wr(4'h7, cc[k]);
      cyc(6);
      chk("accepted", 16'(n + 1), 16'(starts));
      chk("erase", cc[k] == 8'hc0, st_erase);
      rd(4'h7, d, oe);
    end
    n = starts;
    wr(4'h7, 8'hff);
    cyc(6);
    chk("abort start", 16'(n), 16'(starts));
    chk("abort irq", 16'h1, intrq);
    rd(4'h1, d, oe);
    chk("abort code", 8'h04, d);
    rd(4'h7, d, oe);
    chk("abort status", 8'h51, d);
    chk("head used", 4'h5, st_head);
    $display("test class1 done");
  endtask : t_class1

  task automatic t_write(input logic [7:0] code, dh, input logic slw,
    ers, input int max, nb);
    logic [7:0] d, oe, first;
    int n;
    slow = slw;
    wr(4'h6, dh);
    wr(4'h2, 8'h00);
    wr(4'h7, code);
    poll(max, first, d);
    chk("drq no busy", 8'h08, d & 8'h88);
    if (slw) chk("busy first", 16'h1, first[7]);
    chk("count", 9'h100, st_count);
    chk("erase", ers, st_erase);
    chk("fill", code == 8'h50 ? 8'hff : 8'h00, st_fill);
    n = wrs;
    for (int k = 0; k < 4; k++) wr(4'h0, 8'h10 + 8'(k));
    chk("data writes", 16'(nb), 16'(wrs - n));
    if (nb > 0) chk("last byte", 8'h13, st_byte);
    rd(4'h7, d, oe);
    chk("busy after data", 8'h80, d & 8'h88);
    done_req = 1'b1;
    cyc(2);
    done_req = 1'b0;
    cyc(6);
    chk("done irq", 16'h1, intrq);
    rd(4'h7, d, oe);
    chk("done status", 8'h50, d);
    $display("test write %h done", code);
  endtask : t_write

  initial begin
    cyc(3);
    nrst = 1'b1;
    cyc(6);
    t_mirror();
    t_power();
    t_class1();
    t_write(8'h30, 8'ha0, 1'b0, 1'b0, 3, 4);
    t_write(8'h38, 8'ha0, 1'b1, 1'b1, 3, 4);
    t_write(8'hcd, 8'ha0, 1'b1, 1'b1, 5, 4);
    t_write(8'h50, 8'he0, 1'b0, 1'b0, 3, 0);
    report_and_stop();
  end
endmodule : testbench
